// ### rtl/fast_serial_link.v
// fast serial link engine: two channels over one four-wire port
`timescale 1ns/100ps
`include "fast_serial_regs.vh"

// Behaviour
// - any channel in fast mode switches the second channel's pins to the link.
// - mode value 10 holds link reset, host data still taken; 0 releases.
// - with a byte ready, serial output is driven low as start bit.
// - no outgoing frame begins while an incoming frame is in progress.
// - every outgoing frame starts with a zero bit.
// - outgoing data byte shifted least significant bit first after start.
// - outgoing frame ends with source bit, 0 first channel, 1 second.
// - after a zero start bit, accept line drops on next clock rise.
// - incoming data bits 0 to 7 captured in order, lsb first.
// - last bit picks channel; falls to other channel if not fast mode.
// - link engines disabled unless some channel is in fast mode; host data still taken.
// - accept line stays low until another byte can be taken.
// - fast mode comes from nonvolatile configuration inputs only.
module fast_serial_link (
	core_clk,
	rst_n,
	cfg_a_fast_mode,
	cfg_b_fast_mode,
	mode_cmd_valid,
	mode_cmd_value,
	tx_a_valid,
	tx_a_data,
	tx_a_ready,
	tx_b_valid,
	tx_b_data,
	tx_b_ready,
	rx_valid,
	rx_data,
	rx_channel,
	rx_ready,
	fast_serial_clock,
	serial_in_line,
	serial_out_line,
	accept_ready_line,
	b_pins_fast_serial,
	link_held
);
	input  wire       core_clk;
	input  wire       rst_n;
	input  wire       cfg_a_fast_mode;
	input  wire       cfg_b_fast_mode;
	input  wire       mode_cmd_valid;
	input  wire [7:0] mode_cmd_value;
	input  wire       tx_a_valid;
	input  wire [7:0] tx_a_data;
	output wire       tx_a_ready;
	input  wire       tx_b_valid;
	input  wire [7:0] tx_b_data;
	output wire       tx_b_ready;
	output reg        rx_valid;
	output reg  [7:0] rx_data;
	output reg        rx_channel;
	input  wire       rx_ready;
	input  wire       fast_serial_clock;
	input  wire       serial_in_line;
	output reg        serial_out_line;
	output reg        accept_ready_line;
	output wire       b_pins_fast_serial;
	output reg        link_held;

	////////////////////////////////////////////////////////////////////////
	// enable, pin routing, hold
	wire fs_enable = cfg_a_fast_mode | cfg_b_fast_mode;
	assign b_pins_fast_serial = fs_enable;
	wire run = fs_enable & ~link_held;

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			link_held <= 1'b0;
		end else if (mode_cmd_valid) begin
			if (mode_cmd_value == `FS_MODE_HOLD) begin
				link_held <= 1'b1;
			end else if (mode_cmd_value == `FS_MODE_RUN) begin
				link_held <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin sampling; clock and data share one latency so they stay aligned
	wire clk_s;
	wire din_s;
	reg  clk_prev_reg;

	pin_sync3 u_sync_clk (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.pin_in    (fast_serial_clock),
		.level_out (clk_s)
	);
	pin_sync3 u_sync_din (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.pin_in    (serial_in_line),
		.level_out (din_s)
	);

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			clk_prev_reg <= 1'b1;
		end else begin
			clk_prev_reg <= clk_s;
		end
	end

	// only edges seen from outside advance the engines
	wire clk_rise = clk_s & ~clk_prev_reg;

	////////////////////////////////////////////////////////////////////////
	// one-byte holding stage per channel; filled even while held
	reg       txa_full_reg;
	reg       txb_full_reg;
	reg [7:0] txa_byte_reg;
	reg [7:0] txb_byte_reg;
	reg       tx_busy_reg;
	reg [3:0] tx_cnt_reg;
	reg [9:0] tx_frame_reg;
	reg       rx_busy_reg;

	assign tx_a_ready = ~txa_full_reg;
	assign tx_b_ready = ~txb_full_reg;

	// channel a first; a limitation: a busy a stream can starve b
	wire tx_take_a = txa_full_reg;
	wire tx_start  = run & ~tx_busy_reg & ~rx_busy_reg & din_s
		& (txa_full_reg | txb_full_reg);

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			txa_full_reg <= 1'b0;
			txb_full_reg <= 1'b0;
			txa_byte_reg <= 8'h00;
			txb_byte_reg <= 8'h00;
		end else begin
			if (tx_a_valid & ~txa_full_reg) begin
				txa_full_reg <= 1'b1;
				txa_byte_reg <= tx_a_data;
			end else if (tx_start & tx_take_a) begin
				txa_full_reg <= 1'b0;
			end
			if (tx_b_valid & ~txb_full_reg) begin
				txb_full_reg <= 1'b1;
				txb_byte_reg <= tx_b_data;
			end else if (tx_start & ~tx_take_a) begin
				txb_full_reg <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// transmit engine
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_busy_reg     <= 1'b0;
			tx_cnt_reg      <= 4'h0;
			tx_frame_reg    <= 10'h3FF;
			serial_out_line <= `FS_IDLE_LEVEL;
		end else if (!run) begin
			tx_busy_reg     <= 1'b0;
			tx_cnt_reg      <= 4'h0;
			serial_out_line <= `FS_IDLE_LEVEL;
		end else if (tx_start) begin
			tx_busy_reg     <= 1'b1;
			tx_cnt_reg      <= 4'h0;
			if (tx_take_a) begin
				tx_frame_reg <= {`FS_CHAN_A, txa_byte_reg,
					`FS_START_BIT};
			end else begin
				tx_frame_reg <= {`FS_CHAN_B, txb_byte_reg,
					`FS_START_BIT};
			end
			serial_out_line <= `FS_START_BIT;
		end else if (tx_busy_reg & clk_rise) begin
			if (tx_cnt_reg == `FS_LAST_BIT) begin
				tx_busy_reg     <= 1'b0;
				serial_out_line <= `FS_IDLE_LEVEL;
			end else begin
				tx_cnt_reg      <= tx_cnt_reg + 4'h1;
				serial_out_line <= tx_frame_reg[tx_cnt_reg + 4'h1];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// receive engine
	reg [3:0] rx_cnt_reg;
	reg [7:0] rx_shift_reg;

	function route_channel;
		input target_bit;
		input a_on;
		input b_on;
		begin
			if (target_bit == `FS_CHAN_A) begin
				route_channel = a_on ? `FS_CHAN_A : `FS_CHAN_B;
			end else begin
				route_channel = b_on ? `FS_CHAN_B : `FS_CHAN_A;
			end
		end
	endfunction

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_busy_reg       <= 1'b0;
			rx_cnt_reg        <= 4'h0;
			rx_shift_reg      <= 8'h00;
			rx_valid          <= 1'b0;
			rx_data           <= 8'h00;
			rx_channel        <= `FS_CHAN_A;
			accept_ready_line <= 1'b0;
		end else begin
			// delivery clears on handshake; new data cannot collide
			if (rx_valid & rx_ready) begin
				rx_valid <= 1'b0;
			end
			if (!run) begin
				rx_busy_reg       <= 1'b0;
				rx_cnt_reg        <= 4'h0;
				accept_ready_line <= 1'b0;
			end else if (!rx_busy_reg) begin
				accept_ready_line <= ~rx_valid & ~tx_busy_reg;
				if (clk_rise & accept_ready_line
					& (din_s == `FS_START_BIT)) begin
					rx_busy_reg <= 1'b1;
					rx_cnt_reg  <= 4'h0;
				end
			end else if (clk_rise) begin
				if (rx_cnt_reg == 4'h0) begin
					accept_ready_line <= 1'b0;
				end
				if (rx_cnt_reg <= `FS_LAST_DATA) begin
					rx_shift_reg <= {din_s, rx_shift_reg[7:1]};
					rx_cnt_reg   <= rx_cnt_reg + 4'h1;
				end else begin
					rx_busy_reg <= 1'b0;
					rx_valid    <= 1'b1;
					rx_data     <= rx_shift_reg;
					rx_channel  <= route_channel(din_s, cfg_a_fast_mode,
						cfg_b_fast_mode);
				end
			end
		end
	end
endmodule // fast_serial_link

// ### rtl/fast_serial_regs.vh
// constants for the four-wire fast serial link
`ifndef FAST_SERIAL_REGS_VH
`define FAST_SERIAL_REGS_VH
`define FS_FRAME_BITS   4'hA
`define FS_LAST_DATA    4'h7
`define FS_CHAN_BIT     4'h8
`define FS_LAST_BIT     4'h9
`define FS_START_BIT    1'b0
`define FS_IDLE_LEVEL   1'b1
`define FS_CHAN_A       1'b0
`define FS_CHAN_B       1'b1
`define FS_MODE_HOLD    8'h10
`define FS_MODE_RUN     8'h00
`endif

// ### rtl/pin_sync3.v
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module pin_sync3 (
	core_clk,
	rst_n,
	pin_in,
	level_out
);
	input  wire core_clk;
	input  wire rst_n;
	input  wire pin_in;
	output reg  level_out;

	reg s1_reg;
	reg s2_reg;
	reg s3_reg;

	// stage one feeds stage two only; output moves when two and three agree
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_reg    <= 1'b1;
			s2_reg    <= 1'b1;
			s3_reg    <= 1'b1;
			level_out <= 1'b1;
		end else begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin
				level_out <= s3_reg;
			end
		end
	end
endmodule // pin_sync3

// ### verification/fast_serial_link_test.sv
// testbench for the fast serial link
`timescale 1ns/100ps
module fast_serial_link_test;
	reg core_clk = 1'b0, rst_n = 1'b0, ca = 1'b1, cb = 1'b1;
	reg mv = 1'b0, av = 1'b0, bv = 1'b0, rr = 1'b0, ok;
	reg [7:0] mval = 8'h00, ad = 8'h00, bd = 8'h00;
	reg [9:0] v;
	reg lo;
	wire ar, br, rv, rch, sck, sin, sout, cts, bp, held;
	wire [7:0] rd;
	integer fails = 0, checks_done = 0, n;
	always #5 core_clk = ~core_clk;
	fast_serial_link dut (.core_clk(core_clk), .rst_n(rst_n),
		.cfg_a_fast_mode(ca), .cfg_b_fast_mode(cb), .mode_cmd_valid(mv),
		.mode_cmd_value(mval), .tx_a_valid(av), .tx_a_data(ad),
		.tx_a_ready(ar), .tx_b_valid(bv), .tx_b_data(bd), .tx_b_ready(br),
		.rx_valid(rv), .rx_data(rd), .rx_channel(rch), .rx_ready(rr),
		.fast_serial_clock(sck), .serial_in_line(sin),
		.serial_out_line(sout), .accept_ready_line(cts),
		.b_pins_fast_serial(bp), .link_held(held));
	fs_far_end far (.fast_serial_clock(sck), .serial_in_line(sin),
		.serial_out_line(sout), .accept_ready_line(cts));
	task finish_test;
		begin
			$display("checks %0d fails %0d", checks_done, fails);
			if (fails == 0 && checks_done > 0) begin
				$display("Result: passed");
			end else begin
				$display("Result: failed");
			end
			$finish;
		end
	endtask
	task chk(input [9:0] g, input [9:0] e, input [63:0] nm);
		begin
			checks_done = checks_done + 1;
			if (g !== e) begin
				fails = fails + 1;
				$display("unexpected %0s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task lim;
		begin
			n = n + 1;
			if (n > 3000) begin
				fails = fails + 1;
				finish_test;
			end else begin
				@(posedge core_clk);
			end
		end
	endtask
	task t_tx;
		begin
			av <= 1'b1; ad <= 8'hA5; bv <= 1'b1; bd <= 8'h3C;
			@(posedge core_clk);
			av <= 1'b0; bv <= 1'b0;
			#1 chk({ar, br}, 2'b00, "tx taken");
			n = 0; while (sout !== 1'b0) lim;
			far.recv(0, v);
			chk(v, {1'b0, 8'hA5, 1'b0}, "tx a");
			n = 0; while (sout !== 1'b0) lim;
			far.recv(400, v);
			chk(v, {1'b1, 8'h3C, 1'b0}, "tx b");
		end
	endtask
	task t_rx(input a, input b, input tgt, input ch);
		begin
			ca <= a; cb <= b;
			n = 0; while (cts !== 1'b1) lim;
			far.send(8'h96, tgt, ok);
			chk(ok, 1'b1, "sent");
			chk(far.cts_seen, 2'b10, "cts");
			n = 0; while (rv !== 1'b1) lim;
			chk({rch, rd}, {ch, 8'h96}, "rx");
			repeat (30) @(posedge core_clk);
			chk(cts, 1'b0, "cts low");
			rr <= 1'b1;
			@(posedge core_clk);
			rr <= 1'b0;
			n = 0; while (cts !== 1'b1) lim;
			chk(rv, 1'b0, "rx done");
		end
	endtask
	// a byte offered mid-receive must wait; d0 is high so only rx gating holds it
	task t_both;
		begin
			ca <= 1'b1;
			cb <= 1'b1;
			n = 0;
			while (cts !== 1'b1) lim;
			lo = 1'b0;
			fork
				far.send(8'hC3, 1'b0, ok);
				begin
					repeat (20) @(posedge core_clk);
					av <= 1'b1;
					ad <= 8'h5A;
					@(posedge core_clk);
					av <= 1'b0;
					n = 0;
					while (rv !== 1'b1) begin
						if (sout !== 1'b1) lo = 1'b1;
						lim;
					end
				end
			join
			chk(lo, 1'b0, "tx in rx");
			chk({rch, rd}, {1'b0, 8'hC3}, "rx both");
			rr <= 1'b1;
			@(posedge core_clk);
			rr <= 1'b0;
			n = 0;
			while (sout !== 1'b0) lim;
			far.recv(0, v);
			chk(v, {1'b0, 8'h5A, 1'b0}, "tx after");
		end
	endtask
	task t_hold;
		begin
			mv <= 1'b1; mval <= 8'h10;
			@(posedge core_clk);
			mv <= 1'b0; av <= 1'b1; ad <= 8'h0F;
			@(posedge core_clk);
			av <= 1'b0;
			repeat (50) @(posedge core_clk);
			chk({held, ar, sout}, 3'b101, "held");
			mv <= 1'b1; mval <= 8'h00;
			@(posedge core_clk);
			mv <= 1'b0;
			n = 0; while (sout !== 1'b0) lim;
			far.recv(0, v);
			chk(v, {1'b0, 8'h0F, 1'b0}, "freed");
		end
	endtask
	task t_off;
		begin
			ca <= 1'b0; cb <= 1'b0;
			repeat (10) @(posedge core_clk);
			chk({bp, cts, sout}, 3'b001, "off");
			ca <= 1'b1;
			repeat (10) @(posedge core_clk);
			chk(bp, 1'b1, "a only");
		end
	endtask
	initial begin
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (10) @(posedge core_clk);
		t_tx;
		t_rx(1'b1, 1'b1, 1'b1, 1'b1);
		t_rx(1'b1, 1'b1, 1'b0, 1'b0);
		t_rx(1'b0, 1'b1, 1'b0, 1'b1);
		t_rx(1'b1, 1'b0, 1'b1, 1'b0);
		t_both;
		t_hold;
		t_off;
		finish_test;
	end
endmodule // fast_serial_link_test

// ### verification/fs_far_end.sv
// far-end model: makes the serial clock, drives data in
`timescale 1ns/100ps
module fs_far_end (
	output reg  fast_serial_clock,
	output reg  serial_in_line,
	input  wire serial_out_line,
	input  wire accept_ready_line
);
	reg [1:0] cts_seen;
	integer   i;
	// clock stays low between frames; data line is driven high when idle
	initial begin
		fast_serial_clock = 1'b0;
		serial_in_line = 1'b1;
	end
	task send(input [7:0] d, input tgt, output ok);
		reg [9:0] f;
		begin
			#1 f = {tgt, d, 1'b0};
			ok = accept_ready_line;
			for (i = 0; ok && i < 10; i = i + 1) begin
				serial_in_line = f[i];
				#80 fast_serial_clock = 1'b1;
				#80 fast_serial_clock = 1'b0;
				if (i < 2) cts_seen[1 - i] = accept_ready_line;
			end
			serial_in_line = 1'b1;
		end
	endtask
	// stall holds the clock after the start bit, as a busy far end would
	task recv(input integer stall, output [9:0] v);
		begin
			#1 #(stall);
			for (i = 0; i < 10; i = i + 1) begin
				#80 v = {serial_out_line, v[9:1]};
				fast_serial_clock = 1'b1;
				#80 fast_serial_clock = 1'b0;
			end
		end
	endtask
endmodule // fs_far_end

// ### verification/fs_link_chk.sv
// checker for the fast serial link ports
`timescale 1ns/100ps
module fs_link_chk (
	input wire       core_clk,
	input wire       rst_n,
	input wire       cfg_a_fast_mode,
	input wire       cfg_b_fast_mode,
	input wire       mode_cmd_valid,
	input wire [7:0] mode_cmd_value,
	input wire       rx_valid,
	input wire       rx_channel,
	input wire       serial_out_line,
	input wire       accept_ready_line,
	input wire       b_pins_fast_serial,
	input wire       link_held
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	wire on = cfg_a_fast_mode | cfg_b_fast_mode;
	property p_set;
		mode_cmd_valid && mode_cmd_value == 8'h10 |=> link_held;
	endproperty
	a_set: assert property (p_set) else $error("hold not taken");
	property p_clr;
		mode_cmd_valid && mode_cmd_value == 8'h00 |=> !link_held;
	endproperty
	a_clr: assert property (p_clr) else $error("hold not freed");
	property p_hold;
		link_held [*2] |-> serial_out_line && !accept_ready_line;
	endproperty
	a_hold: assert property (p_hold) else $error("held link active");
	property p_pins;
		b_pins_fast_serial == on;
	endproperty
	a_pins: assert property (p_pins) else $error("pin routing wrong");
	// one cycle of slack covers the registered outputs
	property p_off;
		!on [*2] |-> serial_out_line && !accept_ready_line;
	endproperty
	a_off: assert property (p_off) else $error("link active off");
	property p_pend;
		rx_valid |-> !accept_ready_line;
	endproperty
	a_pend: assert property (p_pend) else $error("ready while full");
	property p_to_b;
		rx_valid && cfg_b_fast_mode && !cfg_a_fast_mode |-> rx_channel;
	endproperty
	a_to_b: assert property (p_to_b) else $error("byte not to b");
	property p_to_a;
		rx_valid && cfg_a_fast_mode && !cfg_b_fast_mode |-> !rx_channel;
	endproperty
	a_to_a: assert property (p_to_a) else $error("byte not to a");
endmodule // fs_link_chk
bind fast_serial_link fs_link_chk chk (
	.core_clk           (core_clk),
	.rst_n              (rst_n),
	.cfg_a_fast_mode    (cfg_a_fast_mode),
	.cfg_b_fast_mode    (cfg_b_fast_mode),
	.mode_cmd_valid     (mode_cmd_valid),
	.mode_cmd_value     (mode_cmd_value),
	.rx_valid           (rx_valid),
	.rx_channel         (rx_channel),
	.serial_out_line    (serial_out_line),
	.accept_ready_line  (accept_ready_line),
	.b_pins_fast_serial (b_pins_fast_serial),
	.link_held          (link_held)
);
